// [verilog/dram_link_defines.svh]
`ifndef DRAM_LINK_DEFINES_SVH
`define DRAM_LINK_DEFINES_SVH

// Command codes on {chip select, row strobe, column strobe, write strobe}, all active low.
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WRITE 4'h4
`define CMD_READ 4'h5
`define CMD_NOP 4'h7

// Address bit that picks the precharge scope, or asks for auto precharge on reads and writes.
`define PRE_SCOPE_BIT 8
`define AUTO_PRE_BIT 8

// Burst of four beats; index of the last beat.
`define BURST_LAST 2'd3
`define BURST_BEATS 3'd4

// Reset value of the captured mode word.
`define MODE_RESET 12'h000

// Link clock phase counter: the clock rises after phase 1 and falls after phase 3.
`define CK_PHASE_LAUNCH 2'd0
`define CK_PHASE_RISE 2'd1
`define CK_PHASE_END 2'd3

// Controller register offsets (byte addresses on APB), then the upper address nibble of each data window.
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_MASK 8'h08
`define REG_STATUS 8'h0c
`define REG_WDATA_HI 4'h1
`define REG_RDATA_HI 4'h2

// Field positions in the command and status registers.
`define CMD_OP_LSB 0
`define CMD_BANK_LSB 3
`define CMD_CKE_BIT 6
`define STAT_BUSY_BIT 0
`define STAT_SREF_BIT 1
`define STAT_CKE_BIT 2

`endif

// [verilog/dram_link_pkg.sv]
package dram_link_pkg;
  `include "dram_link_defines.svh"

  typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_REF, OP_MRS} op_t;
  typedef enum logic [1:0] {PWR_ON, PWR_PD_PRE, PWR_PD_ACT, PWR_SREF} pwr_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_WBEAT, ST_RWAIT} ctl_state_t;

  // Maps an operation onto the four active-low command pins.
  function automatic logic [3:0] cmd_code(input op_t op);
    case (op)
      OP_ACT: cmd_code = `CMD_ACT;
      OP_READ: cmd_code = `CMD_READ;
      OP_WRITE: cmd_code = `CMD_WRITE;
      OP_PRE: cmd_code = `CMD_PRE;
      OP_REF: cmd_code = `CMD_REF;
      OP_MRS: cmd_code = `CMD_MRS;
      default: cmd_code = `CMD_NOP;
    endcase
  endfunction
endpackage

// [verilog/dram_link_if.sv]
`timescale 1ns/1ps
interface dram_link_if;
  logic ck_t;
  logic ck_c;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] array_select;
  logic [11:0] address_lines;
  logic [3:0] write_byte_mask;
  logic [3:0] write_strobe_in;
  logic [3:0] read_strobe_out;
  logic [31:0] ctl_dq_out;
  logic ctl_dq_oe_n;
  logic [31:0] dev_dq_out;
  logic dev_dq_oe_n;
  logic [31:0] data_lines;

  // The shared data wire: whoever enables drives it, otherwise it floats high.
  assign data_lines = !ctl_dq_oe_n ? ctl_dq_out : (!dev_dq_oe_n ? dev_dq_out : '1);

  modport mem (
    input ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, array_select, address_lines,
    input write_byte_mask, write_strobe_in, data_lines,
    output read_strobe_out, dev_dq_out, dev_dq_oe_n
  );

  modport ctl (
    output ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, array_select, address_lines,
    output write_byte_mask, write_strobe_in, ctl_dq_out, ctl_dq_oe_n,
    input read_strobe_out, data_lines
  );
endinterface

// [verilog/dram_mem_end.sv]
// Notes on behaviour
// R1 - Commands captured at rising clock crossing.
// R2 - Read data moves on both crossings.
// R3 - Controller keeps clock running except self refresh.
// R4 - Clock enable high enables buffers and drivers.
// R5 - Enable low: precharge/active power-down or self refresh.
// R6 - Enable sync for entries; self-refresh exit asynchronous.
// R7 - Controller holds enable high during accesses; here cke follows the CKE command bit, even for reads and writes.
// R8 - Power-down ignores all but clock and enable.
// R9 - Self refresh ignores all but enable.
// R10 - Chip select high masks every command.
// R11 - Command from strobes plus chip select.
// R12 - Masked write bytes are not written.
// R13 - Bank select picks the target bank.
// R14 - Precharge scope bit: one bank or all.
// R15 - Row from address; column skips bit eight.
// R16 - Bit eight requests auto precharge.
// R17 - Mode register set loads address lines.
// R18 - Read strobe per byte, edge aligned.
// R19 - Write strobe per byte, centred on data.
// R20 - Data lines shared; direction follows access.
// R21 - Customary command truth table decode.
`timescale 1ns/1ps
module dram_mem_end (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CE,
  dram_link_if.mem MEM,
  output logic [11:0] MODE_REG,
  output dram_link_pkg::pwr_t POWER_STATE,
  output logic [7:0] OPEN_BANKS
);
  import dram_link_pkg::*;
  `include "dram_link_defines.svh"

  localparam int PW = 62;

  logic [PW-1:0] pins_raw;
  logic [PW-1:0] meta_q;
  logic [PW-1:0] pins_q;
  pwr_t pwr_q;
  pwr_t pwr_d;
  logic xing_q;
  logic [3:0] wstb_q;
  logic [7:0] open_q;
  logic [1:0] row_lo_q [0:7];
  logic [11:0] mode_q;
  logic rd_act_q;
  logic rd_tail_q;
  logic wr_act_q;
  logic [1:0] beat_q;
  logic [7:0] base_q;
  logic [31:0] dq_q;
  logic [3:0] rstb_q;
  logic oe_n_q;
  logic [31:0] mem_q [0:255];

  // Word address of one beat; the burst wraps inside an aligned group of four.
  function automatic logic [7:0] burst_addr(input logic [7:0] base, input logic [1:0] beat);
    burst_addr = {base[7:2], base[1:0] + beat};
  endfunction

  // Every link input is gathered into one word for the two-stage synchroniser.
  assign pins_raw = {MEM.ck_t, MEM.ck_c, MEM.cke, MEM.cs_n, MEM.ras_n, MEM.cas_n, MEM.we_n,
                     MEM.array_select, MEM.address_lines, MEM.write_byte_mask,
                     MEM.write_strobe_in, MEM.data_lines};

  // Named fields of the synchronised pin word.
  wire ck_t_s = pins_q[61];
  wire ck_c_s = pins_q[60];
  wire cke_s = pins_q[59];
  wire [3:0] cmd_s = pins_q[58:55];
  wire [2:0] ba_s = pins_q[54:52];
  wire [11:0] addr_s = pins_q[51:40];
  wire [3:0] mask_s = pins_q[39:36];
  wire [3:0] wstb_s = pins_q[35:32];
  wire [31:0] dq_s = pins_q[31:0];

  // Input buffer gating by power state and clock crossing detection.
  wire clk_live = (pwr_q != PWR_SREF); // R9
  wire bufs_on = (pwr_q == PWR_ON); // R4 R8
  wire xing = ck_t_s & ~ck_c_s;
  wire rise = clk_live & xing & ~xing_q; // R1
  wire edge_any = clk_live & (xing ^ xing_q); // R2
  wire take = rise & cke_s & bufs_on; // R4

  // Command decode; every code has chip select low, so a deselected cycle matches none.
  wire is_act = take & (cmd_s == `CMD_ACT); // R10 R11 R21
  wire is_rd = take & (cmd_s == `CMD_READ); // R21
  wire is_wr = take & (cmd_s == `CMD_WRITE); // R21
  wire is_pre = take & (cmd_s == `CMD_PRE); // R21
  wire is_mrs = take & (cmd_s == `CMD_MRS); // R17 R21
  wire bank_open = open_q[ba_s]; // R13
  wire rw_go = (is_rd | is_wr) & bank_open;
  wire auto_pre = addr_s[`AUTO_PRE_BIT]; // R16
  wire [7:0] start_addr = {1'b0, ba_s, row_lo_q[ba_s], addr_s[1:0]}; // R15
  wire [7:0] beat_addr = burst_addr(base_q, beat_q);
  wire wr_edge = wr_act_q & bufs_on & (wstb_s != wstb_q); // R8

  // Power state: entries are taken at a rising crossing, self-refresh exit needs no clock edge.
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_ON: begin
        if (rise & ~cke_s) begin // R5 R6
          if ((cmd_s == `CMD_REF) & ~|open_q) begin
            pwr_d = PWR_SREF;
          end else if (|open_q) begin
            pwr_d = PWR_PD_ACT;
          end else begin
            pwr_d = PWR_PD_PRE;
          end
        end
      end
      PWR_PD_PRE, PWR_PD_ACT: begin
        if (rise & cke_s) begin // R6
          pwr_d = PWR_ON;
        end
      end
      PWR_SREF: begin
        if (cke_s) begin // R6
          pwr_d = PWR_ON;
        end
      end
      default: pwr_d = PWR_ON;
    endcase
  end

  // Two-stage synchroniser and edge history.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      meta_q <= '0;
      pins_q <= '0;
      xing_q <= 1'b0;
      wstb_q <= 4'h0;
      pwr_q <= PWR_ON;
    end else if (CE) begin
      meta_q <= pins_raw;
      pins_q <= meta_q;
      xing_q <= xing;
      wstb_q <= wstb_s;
      pwr_q <= pwr_d;
    end
  end

  // Bank bookkeeping and the mode word.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      open_q <= 8'h00;
      mode_q <= `MODE_RESET;
      for (int i = 0; i < 8; i++) begin
        row_lo_q[i] <= 2'b00;
      end
    end else if (CE) begin
      if (is_act) begin // R13 R15
        open_q[ba_s] <= 1'b1;
        row_lo_q[ba_s] <= addr_s[1:0];
      end
      if (is_pre) begin
        if (addr_s[`PRE_SCOPE_BIT]) begin // R14
          open_q <= 8'h00;
        end else begin
          open_q[ba_s] <= 1'b0;
        end
      end
      if (rw_go & auto_pre) begin // R16
        open_q[ba_s] <= 1'b0;
      end
      if (is_mrs) begin // R17
        mode_q <= addr_s;
      end
    end
  end

  // Burst engine: a read beat leaves on every crossing, a write beat lands on every strobe edge.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_act_q <= 1'b0;
      rd_tail_q <= 1'b0;
      wr_act_q <= 1'b0;
      beat_q <= 2'd0;
      base_q <= 8'h00;
      dq_q <= 32'h0000_0000;
      rstb_q <= 4'h0;
      oe_n_q <= 1'b1;
    end else if (CE) begin
      if (rw_go) begin
        base_q <= start_addr;
        beat_q <= 2'd0;
        rd_act_q <= is_rd;
        rd_tail_q <= 1'b0;
        wr_act_q <= is_wr;
      end else if (rd_act_q & edge_any) begin
        dq_q <= mem_q[beat_addr]; // R2
        rstb_q <= ~rstb_q; // R18
        oe_n_q <= 1'b0; // R20
        beat_q <= beat_q + 2'd1;
        if (beat_q == `BURST_LAST) begin
          rd_act_q <= 1'b0;
          rd_tail_q <= 1'b1;
        end
      end else if (rd_tail_q & edge_any) begin
        rd_tail_q <= 1'b0;
        oe_n_q <= 1'b1; // R20
      end else if (wr_edge) begin
        beat_q <= beat_q + 2'd1;
        if (beat_q == `BURST_LAST) begin
          wr_act_q <= 1'b0;
        end
      end
      if (pwr_d != PWR_ON) begin // R4
        rd_act_q <= 1'b0;
        rd_tail_q <= 1'b0;
        wr_act_q <= 1'b0;
        oe_n_q <= 1'b1;
      end
    end
  end

  // Storage: each byte whose mask is low at the strobe edge is written.
  always_ff @(posedge CORE_CLK) begin
    if (CE && wr_edge) begin
      for (int b = 0; b < 4; b++) begin
        if (!mask_s[b]) begin // R12
          mem_q[beat_addr][8*b +: 8] <= dq_s[8*b +: 8];
        end
      end
    end
  end

  // Pin and status outputs.
  assign MEM.dev_dq_out = dq_q;
  assign MEM.dev_dq_oe_n = oe_n_q;
  assign MEM.read_strobe_out = rstb_q;
  assign MODE_REG = mode_q;
  assign POWER_STATE = pwr_q;
  assign OPEN_BANKS = open_q;
endmodule

// [verilog/dram_ctl_end.sv]
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
module dram_ctl_end (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  dram_link_if.ctl LINK
);
  import dram_link_pkg::*;
  `include "dram_link_defines.svh"

  ctl_state_t st_q;
  logic [1:0] ph_q;
  logic ck_q;
  logic cke_q;
  logic sref_q;
  logic [3:0] cmd_pins_q;
  logic [2:0] ba_pins_q;
  logic [11:0] addr_pins_q;
  logic [3:0] mask_pins_q;
  logic [3:0] wstb_q;
  logic [31:0] dq_out_q;
  logic oe_n_q;
  logic [2:0] beat_q;
  logic sub_q;
  logic go_q;
  op_t op_q;
  logic [2:0] bank_q;
  logic cke_req_q;
  logic [11:0] addr_q;
  logic [15:0] mask_q;
  logic [31:0] wd_q [0:3];
  logic [31:0] rd_q [0:3];
  logic [35:0] meta_q;
  logic [35:0] back_q;
  logic [3:0] rstb_prev_q;
  logic [31:0] prdata_q;
  logic ld_q;

  // APB decode; read data is latched one enabled edge before the answer, so a frozen setup waits.
  wire busy = go_q | (st_q != ST_IDLE);
  wire done = PSEL & PENABLE & PREADY;
  wire wr_en = done & PWRITE;
  wire hit_cmd = (PADDR == `REG_CMD);
  wire hit_addr = (PADDR == `REG_ADDR);
  wire hit_mask = (PADDR == `REG_MASK);
  wire hit_stat = (PADDR == `REG_STATUS);
  wire hit_wd = (PADDR[7:4] == `REG_WDATA_HI) & (PADDR[1:0] == 2'b00);
  wire hit_rd = (PADDR[7:4] == `REG_RDATA_HI) & (PADDR[1:0] == 2'b00);
  wire mapped = hit_cmd | hit_addr | hit_mask | hit_stat | hit_wd | hit_rd;
  wire [1:0] widx = PADDR[3:2];
  wire [31:0] status = ({29'h0, cke_q, 2'b00} & (32'h1 << `STAT_CKE_BIT))
                     | ({31'h0, sref_q} << `STAT_SREF_BIT)
                     | ({31'h0, busy} << `STAT_BUSY_BIT);
  wire [31:0] rd_mux = hit_cmd ? {25'h0, cke_req_q, bank_q, op_q} :
                       hit_addr ? {20'h0, addr_q} :
                       hit_mask ? {16'h0, mask_q} :
                       hit_stat ? status :
                       hit_wd ? wd_q[widx] :
                       hit_rd ? rd_q[widx] : 32'h0000_0000;
  assign PREADY = CE & ld_q;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = prdata_q;

  // Read path from the device: strobes and data pass two flip-flops.
  wire [3:0] rstb_s = back_q[35:32];
  wire [31:0] dq_s = back_q[31:0];
  wire rd_beat = (st_q == ST_RWAIT) & (rstb_s != rstb_prev_q);
  wire launch = (st_q == ST_IDLE) & go_q & (ph_q == `CK_PHASE_LAUNCH);

  // Software-visible registers.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      go_q <= 1'b0;
      op_q <= OP_NOP;
      bank_q <= 3'd0;
      cke_req_q <= 1'b0;
      addr_q <= 12'h000;
      mask_q <= 16'h0000;
      prdata_q <= 32'h0000_0000;
      ld_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        wd_q[i] <= 32'h0000_0000;
      end
    end else if (CE) begin
      if (PSEL & ~ld_q) begin
        prdata_q <= rd_mux;
        ld_q <= 1'b1;
      end else if (done | ~PSEL) begin
        ld_q <= 1'b0;
      end
      if (launch) begin
        go_q <= 1'b0;
      end
      if (wr_en & hit_cmd & ~busy) begin
        op_q <= op_t'(PWDATA[`CMD_OP_LSB +: 3]);
        bank_q <= PWDATA[`CMD_BANK_LSB +: 3];
        cke_req_q <= PWDATA[`CMD_CKE_BIT];
        go_q <= 1'b1;
      end
      if (wr_en & hit_addr) begin
        addr_q <= PWDATA[11:0];
      end
      if (wr_en & hit_mask) begin
        mask_q <= PWDATA[15:0];
      end
      if (wr_en & hit_wd) begin
        wd_q[widx] <= PWDATA;
      end
    end
  end

  // Link clock divider; it stands low while the device is in self refresh.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ph_q <= 2'd0;
      ck_q <= 1'b0;
      meta_q <= '0;
      back_q <= '0;
      rstb_prev_q <= 4'h0;
    end else if (CE) begin
      meta_q <= {LINK.read_strobe_out, LINK.data_lines};
      back_q <= meta_q;
      rstb_prev_q <= rstb_s;
      if (!sref_q) begin // R3
        ph_q <= ph_q + 2'd1;
        if (ph_q == `CK_PHASE_RISE) begin
          ck_q <= 1'b1;
        end else if (ph_q == `CK_PHASE_END) begin
          ck_q <= 1'b0;
        end
      end
    end
  end

  // Sequencer: command for phases 1 to 3 of one link period, then write beats or read collection.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= ST_IDLE;
      cke_q <= 1'b0;
      sref_q <= 1'b0;
      cmd_pins_q <= `CMD_NOP;
      ba_pins_q <= 3'd0;
      addr_pins_q <= 12'h000;
      mask_pins_q <= 4'h0;
      wstb_q <= 4'h0;
      dq_out_q <= 32'h0000_0000;
      oe_n_q <= 1'b1;
      beat_q <= 3'd0;
      sub_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        rd_q[i] <= 32'h0000_0000;
      end
    end else if (CE) begin
      case (st_q)
        ST_IDLE: begin
          if (launch) begin
            cmd_pins_q <= cmd_code(op_q); // R11 R21
            ba_pins_q <= bank_q; // R13
            addr_pins_q <= addr_q; // R14 R15 R16 R17
            cke_q <= cke_req_q; // R6 R7
            if (cke_req_q) begin
              sref_q <= 1'b0; // R6
            end
            beat_q <= 3'd0;
            sub_q <= 1'b0;
            st_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (ph_q == `CK_PHASE_END) begin
            cmd_pins_q <= `CMD_NOP;
            if (op_q == OP_WRITE) begin
              st_q <= ST_WBEAT;
            end else if (op_q == OP_READ) begin
              st_q <= ST_RWAIT;
            end else begin
              sref_q <= (op_q == OP_REF) & ~cke_q;
              st_q <= ST_IDLE;
            end
          end
        end
        ST_WBEAT: begin
          sub_q <= ~sub_q;
          if (!sub_q) begin
            if (beat_q == `BURST_BEATS) begin
              oe_n_q <= 1'b1;
              st_q <= ST_IDLE;
            end else begin
              dq_out_q <= wd_q[beat_q[1:0]]; // R20
              mask_pins_q <= mask_q[4*beat_q[1:0] +: 4]; // R12
              oe_n_q <= 1'b0; // R20
            end
          end else begin
            wstb_q <= ~wstb_q; // R19
            beat_q <= beat_q + 3'd1;
          end
        end
        ST_RWAIT: begin
          if (rd_beat) begin
            rd_q[beat_q[1:0]] <= dq_s;
            beat_q <= beat_q + 3'd1;
            if (beat_q[1:0] == `BURST_LAST) begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Link pins.
  assign LINK.ck_t = ck_q;
  assign LINK.ck_c = ~ck_q;
  assign LINK.cke = cke_q;
  assign LINK.cs_n = cmd_pins_q[3];
  assign LINK.ras_n = cmd_pins_q[2];
  assign LINK.cas_n = cmd_pins_q[1];
  assign LINK.we_n = cmd_pins_q[0];
  assign LINK.array_select = ba_pins_q;
  assign LINK.address_lines = addr_pins_q;
  assign LINK.write_byte_mask = mask_pins_q;
  assign LINK.write_strobe_in = wstb_q;
  assign LINK.ctl_dq_out = dq_out_q;
  assign LINK.ctl_dq_oe_n = oe_n_q;
endmodule

// [verification/dram_link_props.sv]
`timescale 1ns/1ps
`include "dram_link_defines.svh"
module dram_link_props (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic ck_t,
  input wire logic ck_c,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] array_select,
  input wire logic [11:0] address_lines,
  input wire logic [3:0] write_strobe_in,
  input wire logic [3:0] read_strobe_out,
  input wire logic ctl_dq_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic [31:0] dev_dq_out,
  input wire logic [31:0] data_lines
);
  // The four command pins as one code word.
  wire logic [3:0] cmd_pins = {cs_n, ras_n, cas_n, we_n};

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  // Link clock shape and the command it carries.
  a_ck_pair_complement: assert property (ck_c == ~ck_t)
    else $error("link clock pair not complementary");
  a_ck_high_two: assert property ($rose(ck_t) |=> ck_t ##1 !ck_t)
    else $error("link clock high phase not two cycles");
  a_cmd_held_rise: assert property ($rose(ck_t) |-> $stable(cmd_pins) && $stable(cke) &&
    $stable(array_select) && $stable(address_lines))
    else $error("command pins moved at the capturing crossing");
  a_nop_after_fall: assert property ($fell(ck_t) |-> cmd_pins == `CMD_NOP)
    else $error("command pins not idle after the clock falls");
  // Data wire ownership and clock gate during transfers.
  a_cke_in_access: assert property ((!ctl_dq_oe_n || !dev_dq_oe_n) |-> cke)
    else $error("clock gate low during a data transfer");
  a_single_driver: assert property (!(!ctl_dq_oe_n && !dev_dq_oe_n))
    else $error("both ends drive the data lines");
  // Read beats: all lanes toggle together with data and hold two cycles.
  a_read_lanes_edge: assert property ($changed(read_strobe_out) |-> !dev_dq_oe_n &&
    (read_strobe_out == 4'h0 || read_strobe_out == 4'hf))
    else $error("read strobe toggled without driven data");
  a_read_beat_hold: assert property ($changed(read_strobe_out) |=>
    $stable(read_strobe_out) && $stable(dev_dq_out))
    else $error("read beat shorter than two cycles");
  // Write strobe moves only in the middle of a stable, driven beat.
  a_write_centre: assert property ($changed(write_strobe_in) |-> !ctl_dq_oe_n &&
    $stable(data_lines) && (write_strobe_in == 4'h0 || write_strobe_in == 4'hf))
    else $error("write strobe not centred on stable data");

  cover property ($changed(read_strobe_out));
  cover property ($changed(write_strobe_in));
  cover property ($fell(cke));
  cover property ($rose(ck_t) && cmd_pins == `CMD_PRE && address_lines[8]);
endmodule

// [verification/dram_pin_command_interface_bench.sv]
`timescale 1ns/1ps
module dram_pin_command_interface_bench;
  import dram_link_pkg::*;
  typedef struct {logic [31:0] exp; logic [31:0] care; logic err;} note_t;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] mode_reg;
  pwr_t power_state;
  logic [7:0] open_banks;
  logic [15:0] lfsr_q = 16'h1392;
  int err_count = 0;
  int cmp_count = 0;
  note_t notes[$];
  logic [31:0] wd_a[4];
  logic [31:0] wd_b[4];
  logic [31:0] exp_w[4];
  logic [31:0] r;
  logic [31:0] last_rd;
  logic [15:0] wmask;
  logic [2:0] b;

  dram_link_if dram_link_if_i ();
  dram_ctl_end dram_ctl_end_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(dram_link_if_i));
  dram_mem_end dram_mem_end_i (.CORE_CLK(core_clk), .RESET_N(reset_n), .CE(ce),
    .MEM(dram_link_if_i), .MODE_REG(mode_reg), .POWER_STATE(power_state), .OPEN_BANKS(open_banks));
  dram_link_props dram_link_props_i (.CORE_CLK(core_clk), .RESET_N(reset_n),
    .ck_t(dram_link_if_i.ck_t), .ck_c(dram_link_if_i.ck_c), .cke(dram_link_if_i.cke),
    .cs_n(dram_link_if_i.cs_n), .ras_n(dram_link_if_i.ras_n), .cas_n(dram_link_if_i.cas_n),
    .we_n(dram_link_if_i.we_n), .array_select(dram_link_if_i.array_select),
    .address_lines(dram_link_if_i.address_lines), .write_strobe_in(dram_link_if_i.write_strobe_in),
    .read_strobe_out(dram_link_if_i.read_strobe_out), .ctl_dq_oe_n(dram_link_if_i.ctl_dq_oe_n),
    .dev_dq_oe_n(dram_link_if_i.dev_dq_oe_n), .dev_dq_out(dram_link_if_i.dev_dq_out),
    .data_lines(dram_link_if_i.data_lines));

  // Free-running 50 MHz core clock.
  always #10 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd(output logic [31:0] v);
    lfsr_q = lfsr_step(lfsr_q);
    v = {lfsr_q, lfsr_step(lfsr_q)};
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 100) begin
      err_count++;
      $display("Error at %0t: no bus answer", $time);
    end
    last_rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  // A read notes its expectation first; the monitor below compares it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] c,
    input logic er);
    notes.push_back('{e, c, er});
    apb(a, 1'b0, 32'h0);
  endtask

  // Issue one link command and poll until the controller is idle again.
  task automatic op(input op_t o, input logic [2:0] bk, input logic k, input logic [11:0] ad);
    int n;
    n = 0;
    wr(8'h04, {20'h0, ad});
    wr(8'h00, {25'h0, k, bk, o});
    do begin
      rd(8'h0c, 32'h0, 32'h0, 1'b0);
      n++;
    end while (last_rd[0] !== 1'b0 && n < 40);
    check({31'h0, last_rd[0]}, 32'h0);
    repeat (4) @(posedge core_clk);
  endtask

  // Completed reads are matched against the oldest noted expectation.
  always @(posedge core_clk) begin
    note_t nt;
    if (psel && penable && pready && !pwrite) begin
      if (notes.size() == 0) begin
        err_count++;
        $display("Error at %0t: read with no expectation", $time);
      end else begin
        nt = notes.pop_front();
        check(prdata & nt.care, nt.exp & nt.care);
        check({31'h0, pslverr}, {31'h0, nt.err});
      end
    end
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    check({10'h0, mode_reg, power_state, open_banks}, {10'h0, 12'h000, PWR_ON, 8'h00});
    rd(8'h0c, 32'h0, 32'hffffffff, 1'b0);
    rd(8'h40, 32'h0, 32'hffffffff, 1'b1);
    wr(8'h40, 32'hffffffff);
    op(OP_NOP, 3'h0, 1'b1, 12'h000);
    rd(8'h0c, 32'h4, 32'h7, 1'b0);
    rnd(r);
    b = r[18:16];
    op(OP_MRS, r[22:20], 1'b1, r[11:0]);
    check({20'h0, mode_reg}, {20'h0, r[11:0]});
    op(OP_ACT, b, 1'b1, r[11:0]);
    check({24'h0, open_banks}, {24'h0, 8'h01 << b});
    // Full write at column 0, then a masked write that wraps from column 2.
    for (int k = 0; k < 4; k++) begin
      rnd(wd_a[k]);
      rnd(wd_b[k]);
      wr(8'h10 + 8'(4 * k), wd_a[k]);
    end
    wr(8'h08, 32'h0);
    op(OP_WRITE, b, 1'b1, 12'h000);
    for (int k = 0; k < 4; k++)
      wr(8'h10 + 8'(4 * k), wd_b[k]);
    rnd(r);
    wmask = r[15:0];
    wr(8'h08, {16'h0, wmask});
    op(OP_WRITE, b, 1'b1, 12'h002);
    for (int w = 0; w < 4; w++)
      for (int j = 0; j < 4; j++)
        exp_w[w][8*j +: 8] = wmask[4*((w+2)%4) + j] ? wd_a[w][8*j +: 8] : wd_b[(w+2)%4][8*j +: 8];
    // Read back twice; the second read asks for auto precharge.
    for (int p = 0; p < 2; p++) begin
      op(OP_READ, b, 1'b1, p ? 12'h100 : 12'h000);
      for (int w = 0; w < 4; w++)
        rd(8'h20 + 8'(4 * w), exp_w[w], 32'hffffffff, 1'b0);
    end
    check({24'h0, open_banks}, 32'h0);
    op(OP_ACT, b, 1'b1, 12'h000);
    op(OP_ACT, b ^ 3'h1, 1'b1, 12'h000);
    op(OP_PRE, b, 1'b1, 12'h000);
    check({24'h0, open_banks}, {24'h0, 8'h01 << (b ^ 3'h1)});
    op(OP_PRE, b, 1'b1, 12'h100);
    check({24'h0, open_banks}, 32'h0);
    // Power-down with a row open, a command ignored, then exit.
    op(OP_ACT, b, 1'b1, 12'h000);
    op(OP_NOP, 3'h0, 1'b0, 12'h000);
    check({30'h0, power_state}, {30'h0, PWR_PD_ACT});
    op(OP_ACT, b ^ 3'h1, 1'b0, 12'h000);
    check({22'h0, open_banks, power_state}, {22'h0, 8'h01 << b, PWR_PD_ACT});
    op(OP_NOP, 3'h0, 1'b1, 12'h000);
    check({30'h0, power_state}, {30'h0, PWR_ON});
    op(OP_PRE, b, 1'b1, 12'h100);
    op(OP_NOP, 3'h0, 1'b0, 12'h000);
    check({30'h0, power_state}, {30'h0, PWR_PD_PRE});
    op(OP_NOP, 3'h0, 1'b1, 12'h000);
    op(OP_REF, 3'h0, 1'b1, 12'h000);
    check({30'h0, power_state}, {30'h0, PWR_ON});
    // Self refresh: link clock stands still, exit needs no clock edge.
    op(OP_REF, 3'h0, 1'b0, 12'h000);
    check({30'h0, power_state}, {30'h0, PWR_SREF});
    rd(8'h0c, 32'h2, 32'h3, 1'b0);
    repeat (8) begin
      @(posedge core_clk);
      check({31'h0, dram_link_if_i.ck_t}, 32'h0);
    end
    op(OP_NOP, 3'h0, 1'b1, 12'h000);
    check({30'h0, power_state}, {30'h0, PWR_ON});
    // A stalled APB access waits for pready.
    fork
      begin
        ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
      end
      rd(8'h20, exp_w[0], 32'hffffffff, 1'b0);
    join
    tally_and_finish();
  end
endmodule
